/* hdl/asr_regs.vh */
`ifndef ASR_REGS_VH
`define ASR_REGS_VH
// register byte offsets
`define ASR_OFS_CTRL 12'h000
`define ASR_OFS_BAUD 12'h004
`define ASR_OFS_DATA 12'h008
`define ASR_OFS_STAT 12'h00c
`define ASR_OFS_IRQ_STAT 12'h010
`define ASR_OFS_IRQ_EN 12'h014
`define ASR_OFS_IRQ_CLR 12'h018
// control field positions
`define ASR_CTRL_PORT_EN 0
`define ASR_CTRL_CONT_RX 1
`define ASR_CTRL_SYNC 2
`define ASR_CTRL_RXIE 3
`define ASR_CTRL_PERIPH_IE 4
`define ASR_CTRL_GLOBAL_IE 5
`define ASR_CTRL_NINE 6
// status field positions
`define ASR_STAT_FLAG 0
`define ASR_STAT_OERR 1
`define ASR_STAT_FERR 2
`define ASR_STAT_RX9D 3
`define ASR_STAT_CNT 4
// event bits
`define ASR_EV_CHAR 0
`define ASR_EV_OVR 1
`define ASR_EV_FERR 2
`define ASR_EV_W 3
// reset values
`define ASR_CTRL_RST 7'h00
`define ASR_BAUD_RST 16'h0000
// oversampling and fifo depth
`define ASR_OVS 16
`define ASR_OVS_HALF 8
`define ASR_FIFO_DEPTH 2
`endif

/* hdl/asr_baud_tick.v */
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.vh"
// ***************************************
// oversample tick divider
// ***************************************
module asr_baud_tick
(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // control
    input wire enable,
    input wire [15:0] divisor,
    // one-cycle tick at sixteen times the baud rate
    output reg tick
);
    reg [15:0] cnt_reg; // counts down to next tick

    // divisor value n gives one tick each n+1 clocks
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end
        else if (!enable)
        begin
            // held idle so the first tick is a full period away
            cnt_reg <= divisor;
            tick <= 1'b0;
        end
        else if (cnt_reg == 16'h0000)
        begin
            cnt_reg <= divisor;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg - 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* hdl/asr_receiver.v */
// Overview of operation
// - line oversampled sixteen times per bit
// - finished character moves into two-entry FIFO
// - data only through receive data register
// - falling edge starts character, start bit zero
// - half bit later confirm start low
// - high start midpoint drops silently
// - full bit steps, majority vote each bit
// - stop bit zero sets framing error
// - after stop push FIFO, set flag
// - data read returns and pops oldest
// - overrun blocks reception until cleared
// - flag shows unread data, read only
// - flag irq needs three enables together; overrun and framing events irq through irq_en_reg mask only
// - flag independent of interrupt enables
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "asr_regs.vh"
module asr_receiver
(
    // clock and reset
    input wire hclk,
    input wire hresetn,
    // ahb-lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    // serial line
    input wire rx_line_pin,
    // interrupt
    output wire irq
);
    // ***************************************
    // declarations
    // ***************************************
    localparam ST_IDLE = 4'b0001; // waiting for falling edge
    localparam ST_START = 4'b0010; // checking start midpoint
    localparam ST_DATA = 4'b0100; // taking data bits
    localparam ST_STOP = 4'b1000; // sampling stop bit

    reg [6:0] ctrl_reg; // control bits
    reg [15:0] baud_reg; // tick divisor
    reg [2:0] irq_stat_reg; // sticky events
    reg [2:0] irq_en_reg; // event enables
    reg [3:0] state_reg; // recovery state
    reg [3:0] ovs_reg; // oversample phase
    reg [3:0] bitn_reg; // data bits taken
    reg [8:0] rx_shift_reg; // shift register
    reg [2:0] vote_reg; // three samples near centre
    reg line_d_reg; // previous line level
    reg [9:0] fifo_mem [0:1]; // {ferr, 9 data}
    reg wr_ptr_reg; // write slot
    reg rd_ptr_reg; // read slot
    reg [1:0] count_reg; // entries held
    reg oerr_reg; // overrun latched
    reg ap_valid_reg; // captured address phase
    reg ap_write_reg; // captured direction
    reg [11:0] ap_addr_reg; // captured address

    wire rx_on; // receiver fully enabled
    wire tick; // sixteen times baud
    wire fifo_full;
    wire push; // character completed
    wire pop; // data register read
    wire [9:0] head; // oldest entry
    wire rx_char_flag; // unread data present
    wire [2:0] ev; // this cycle's events
    wire stop_bit; // voted stop level
    wire data_rd; // read of data register
    wire wr_ctrl;
    wire wr_clr;

    // ***************************************
    // helpers
    // ***************************************
    // two-of-three majority
    function maj3;
        input [2:0] v;
        begin
            maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
        end
    endfunction

    // address match for the captured phase
    function hit;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit = (a == ofs);
        end
    endfunction

    // ***************************************
    // bus slave
    // ***************************************
    assign hreadyout = 1'b1; // zero wait states
    assign hresp = 1'b0; // always okay

    // capture address phase of a valid transfer
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg <= 12'h000;
        end
        else if (hready)
        begin
            ap_valid_reg <= hsel & htrans[1];
            ap_write_reg <= hwrite;
            ap_addr_reg <= haddr;
        end
    end

    assign wr_ctrl = ap_valid_reg & ap_write_reg;
    assign wr_clr = wr_ctrl & hit(ap_addr_reg, `ASR_OFS_IRQ_CLR);
    // read data is decoded in the address phase and popped there
    assign data_rd = hready & hsel & htrans[1] & ~hwrite & (haddr == `ASR_OFS_DATA);
    assign pop = data_rd & (count_reg != 2'b00);

    // read mux registered so data stands in the data phase
    // no path exposes the shift register or non-head slots
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h00000000;
        else if (hready & hsel & htrans[1] & ~hwrite)
        begin
            case (haddr)
                `ASR_OFS_CTRL: hrdata <= {25'h0000000, ctrl_reg};
                `ASR_OFS_BAUD: hrdata <= {16'h0000, baud_reg};
                `ASR_OFS_DATA: hrdata <= {24'h000000, head[7:0]};
                `ASR_OFS_STAT: hrdata <= {26'h0000000, count_reg, head[8], head[9], oerr_reg, rx_char_flag};
                `ASR_OFS_IRQ_STAT: hrdata <= {29'h00000000, irq_stat_reg};
                `ASR_OFS_IRQ_EN: hrdata <= {29'h00000000, irq_en_reg};
                default: hrdata <= 32'h00000000; // unmapped and write-only
            endcase
        end
    end

    // writable registers
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_reg <= `ASR_CTRL_RST;
            baud_reg <= `ASR_BAUD_RST;
            irq_en_reg <= 3'h0;
        end
        else if (wr_ctrl)
        begin
            if (hit(ap_addr_reg, `ASR_OFS_CTRL))
                ctrl_reg <= hwdata[6:0];
            if (hit(ap_addr_reg, `ASR_OFS_BAUD))
                baud_reg <= hwdata[15:0];
            if (hit(ap_addr_reg, `ASR_OFS_IRQ_EN))
                irq_en_reg <= hwdata[2:0];
        end
    end

    // ***************************************
    // data recovery
    // ***************************************
    // async reception needs enable, port on and sync clear
    assign rx_on = ctrl_reg[`ASR_CTRL_PORT_EN] & ctrl_reg[`ASR_CTRL_CONT_RX]
                   & ~ctrl_reg[`ASR_CTRL_SYNC];

    asr_baud_tick u_tick
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(rx_on),
        .divisor(baud_reg),
        .tick(tick)
    );

    assign stop_bit = maj3(vote_reg);
    assign push = tick & (state_reg == ST_STOP) & (ovs_reg == 4'hf) & ~fifo_full & ~oerr_reg;

    // recovery state machine, moves on oversample ticks except the return to idle when rx_on drops
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg <= ST_IDLE;
            ovs_reg <= 4'h0;
            bitn_reg <= 4'h0;
            rx_shift_reg <= 9'h000;
            vote_reg <= 3'h7;
            line_d_reg <= 1'b1;
        end
        else if (!rx_on)
        begin
            state_reg <= ST_IDLE;
            line_d_reg <= 1'b1;
        end
        else if (tick)
        begin
            line_d_reg <= rx_line_pin;
            ovs_reg <= ovs_reg + 4'h1;
            // samples 7, 8, 9 of each bit feed the vote
            if (ovs_reg >= 4'h6 && ovs_reg <= 4'h8)
                vote_reg <= {vote_reg[1:0], rx_line_pin};
            case (state_reg)
                ST_IDLE:
                begin
                    if (line_d_reg & ~rx_line_pin & ~oerr_reg)
                    begin
                        state_reg <= ST_START;
                        ovs_reg <= 4'h1;
                    end
                end
                ST_START:
                begin
                    if (ovs_reg == 4'h9)
                    begin
                        if (maj3(vote_reg))
                            state_reg <= ST_IDLE; // no error
                        else
                            bitn_reg <= 4'h0;
                    end
                    if (ovs_reg == 4'hf)
                        state_reg <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (ovs_reg == 4'h9)
                    begin
                        // lsb arrives first, shifts toward bit 0
                        if (ctrl_reg[`ASR_CTRL_NINE])
                            rx_shift_reg <= {maj3(vote_reg), rx_shift_reg[8:1]};
                        else
                            rx_shift_reg <= {1'b0, maj3(vote_reg), rx_shift_reg[7:1]};
                        bitn_reg <= bitn_reg + 4'h1;
                    end
                    if (ovs_reg == 4'hf && bitn_reg == (ctrl_reg[`ASR_CTRL_NINE] ? 4'h9 : 4'h8))
                        state_reg <= ST_STOP;
                end
                ST_STOP:
                begin
                    // decision taken at end of stop bit so vote is complete
                    if (ovs_reg == 4'hf)
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ***************************************
    // two-entry fifo
    // ***************************************
    assign fifo_full = (count_reg == 2'b10);
    assign head = fifo_mem[rd_ptr_reg];

    // write side and occupancy
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'b00;
            fifo_mem[0] <= 10'h000;
            fifo_mem[1] <= 10'h000;
        end
        else
        begin
            if (push)
            begin
                // framing error stored with its character
                fifo_mem[wr_ptr_reg] <= {~stop_bit, rx_shift_reg};
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    // overrun: third character finishing with fifo full
    // cleared by dropping the continuous receive enable
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            oerr_reg <= 1'b0;
        else if (tick & (state_reg == ST_STOP) & (ovs_reg == 4'hf) & fifo_full)
            oerr_reg <= 1'b1;
        else if (!ctrl_reg[`ASR_CTRL_CONT_RX])
            oerr_reg <= 1'b0;
    end

    // ***************************************
    // flag and interrupts
    // ***************************************
    // derived from fifo state and rx_on only, no write path
    assign rx_char_flag = rx_on & (count_reg != 2'b00);

    assign ev[`ASR_EV_CHAR] = push;
    assign ev[`ASR_EV_OVR] = tick & (state_reg == ST_STOP) & (ovs_reg == 4'hf) & fifo_full & ~oerr_reg;
    assign ev[`ASR_EV_FERR] = push & ~stop_bit;

    // sticky events, set beats a same-cycle clear
    always @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq_stat_reg <= 3'h0;
        else
            irq_stat_reg <= (irq_stat_reg & ~(wr_clr ? hwdata[2:0] : 3'h0)) | ev;
    end

    // flag path needs all three enables; overrun and framing events use mask
    assign irq = (rx_char_flag & ctrl_reg[`ASR_CTRL_RXIE] & ctrl_reg[`ASR_CTRL_PERIPH_IE]
                  & ctrl_reg[`ASR_CTRL_GLOBAL_IE])
                 | (|(irq_stat_reg & irq_en_reg & 3'h6));
endmodule
`default_nettype wire

/* verif/asr_tx_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// far-side serial transmitter
// ****
module asr_tx_model
#(
    parameter int BIT_CLKS = 16
)
(
    // bit timing reference
    input wire logic hclk,
    // serial line, high when idle
    output logic line
);
    // plain digital levels only, as a pin set up as digital input sees them
    initial
        line = 1'b1;
    // one bit period at a level
    task automatic hold_bit(input logic v);
        line <= v;
        repeat (BIT_CLKS) @(posedge hclk);
    endtask
    // start, data lsb first, stop, one idle bit so the push lands
    task automatic send(input logic [8:0] d, input int n, input logic stp);
        hold_bit(1'b0);
        for (int i = 0; i < n; i++)
            hold_bit(d[i]);
        hold_bit(stp);
        hold_bit(1'b1);
    endtask
    // low pulse gone before mid start bit
    task automatic glitch();
        line <= 1'b0;
        repeat (4) @(posedge hclk);
        repeat (2) hold_bit(1'b1);
    endtask
endmodule
`default_nettype wire

/* verif/asr_receiver_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bus-side checks of the receiver
// ****
module asr_receiver_monitor
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // line and interrupt
    input wire logic rx_line_pin,
    input wire logic irq
);
    logic ap_v; // data phase of a taken transfer
    logic ap_w;
    logic [11:0] ap_a;
    logic [6:0] ctrl_s; // shadow of control word
    logic [2:0] ien_s; // shadow of event enables
    wire rd_dp = ap_v & ~ap_w;
    wire st_rd = rd_dp & (ap_a == 12'h00c);
    // address phase kept for its data phase
    always_ff @(posedge hclk)
        {ap_w, ap_a} <= {hwrite, haddr};
    // shadows follow writes at end of data phase, as the design does
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_v <= 1'b0;
            ctrl_s <= 7'h00;
            ien_s <= 3'h0;
        end
        else
        begin
            ap_v <= hsel & htrans[1] & hready;
            if (ap_v & ap_w & (ap_a == 12'h000))
                ctrl_s <= hwdata[6:0];
            if (ap_v & ap_w & (ap_a == 12'h014))
                ien_s <= hwdata[2:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    okay_resp_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    irq_gated_a: assert property ((ctrl_s[5:3] != 3'h7 && ien_s == 3'h0) |-> !irq)
        else $error("irq without all enables");
    unmapped_zero_a: assert property (rd_dp && ap_a >= 12'h01c |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    depth_two_a: assert property (st_rd |-> hrdata[5:4] != 2'h3)
        else $error("fifo count above two");
    flag_count_a: assert property (st_rd && $past(ctrl_s[2:0]) == 3'h3
        |-> hrdata[0] == (hrdata[5:4] != 2'h0))
        else $error("flag disagrees with count");
    reserved_zero_a: assert property (st_rd |-> hrdata[31:6] == 26'h0)
        else $error("status upper bits set");
    ctrl_back_a: assert property (rd_dp && ap_a == 12'h000
        |-> hrdata == {25'h0, $past(ctrl_s)})
        else $error("control readback wrong");
    irq_hold_a: assert property ($fell(irq) |-> ap_v || $past(ap_v))
        else $error("irq dropped with no bus access");
    cover property (st_rd && hrdata[5:4] == 2'h2);
    cover property ($rose(irq));
    cover property (st_rd && hrdata[1]);
endmodule
bind asr_receiver asr_receiver_monitor asr_receiver_monitor_inst (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_line_pin(rx_line_pin), .irq(irq));
`default_nettype wire

/* verif/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// self-checking bench for the receiver
// ****
module testbench;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // whole words only
    logic [31:0] hwdata = 32'h0;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire rx_line;
    wire irq;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] r; // last read data
    // divisor 0 gives sixteen clocks a bit
    asr_tx_model #(.BIT_CLKS(16)) asr_tx_model_inst (.hclk(hclk), .line(rx_line));
    asr_receiver asr_receiver_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .rx_line_pin(rx_line), .irq(irq));
    initial
        forever #50 hclk = ~hclk;
    task automatic close_out();
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // single transfer; read data taken at the edge ending the data phase
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
            @(posedge hclk);
        r = hrdata;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string n);
        xfer(1'b0, a, 32'h0);
        chk(n, r, e);
    endtask
    // irq is combinational: look one edge after the last write
    task automatic irq_is(input logic e);
        @(posedge hclk);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    // hang guard, well above the run length
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(1'b1, 12'h004, 32'h0);
        xfer(1'b1, 12'h000, 32'h3);
        xfer(1'b1, 12'h014, 32'h4);
        rd(12'h00c, 32'h0, "stat idle");
        asr_tx_model_inst.send(9'h0a5, 8, 1'b1);
        rd(12'h00c, 32'h11, "stat one");
        irq_is(1'b0);
        rd(12'h008, 32'ha5, "data");
        rd(12'h00c, 32'h0, "stat popped");
        asr_tx_model_inst.send(9'h03c, 8, 1'b1);
        asr_tx_model_inst.send(9'h0c3, 8, 1'b1);
        rd(12'h00c, 32'h21, "stat two");
        rd(12'h008, 32'h3c, "data oldest");
        rd(12'h008, 32'hc3, "data next");
        asr_tx_model_inst.glitch();
        rd(12'h00c, 32'h0, "stat glitch");
        rd(12'h010, 32'h1, "events glitch");
        asr_tx_model_inst.send(9'h055, 8, 1'b0);
        rd(12'h00c, 32'h15, "stat ferr");
        irq_is(1'b1);
        rd(12'h010, 32'h5, "events ferr");
        xfer(1'b1, 12'h018, 32'h7);
        irq_is(1'b0);
        rd(12'h010, 32'h0, "events cleared");
        rd(12'h008, 32'h55, "data ferr");
        asr_tx_model_inst.send(9'h081, 8, 1'b1);
        // every mix of the three enables; only all three raise irq
        for (int k = 0; k < 8; k++)
        begin
            xfer(1'b1, 12'h000, 32'h3 | (k << 3));
            irq_is(k == 7);
        end
        xfer(1'b1, 12'h000, 32'h3);
        rd(12'h00c, 32'h11, "stat no enables");
        rd(12'h008, 32'h81, "data gated");
        for (int k = 1; k < 4; k++)
            asr_tx_model_inst.send(9'(k), 8, 1'b1);
        rd(12'h00c, 32'h23, "stat overrun");
        rd(12'h008, 32'h1, "data ovr a");
        rd(12'h008, 32'h2, "data ovr b");
        asr_tx_model_inst.send(9'h004, 8, 1'b1);
        rd(12'h00c, 32'h2, "stat blocked");
        xfer(1'b1, 12'h000, 32'h1);
        xfer(1'b1, 12'h000, 32'h43);
        asr_tx_model_inst.send(9'h1a5, 9, 1'b1);
        rd(12'h00c, 32'h19, "stat nine");
        xfer(1'b0, 12'h008, 32'h0);
        chk("data nine", {24'h0, r[7:0]}, 32'ha5);
        xfer(1'b1, 12'h01c, 32'hffffffff);
        rd(12'h01c, 32'h0, "unmapped");
        close_out();
    end
endmodule
`default_nettype wire
